// ==== mcc_defines.svh ====
// Constants for the Manchester II word codec: register map, field layout and counts.
// Assumes a single 100 MHz system clock; all timing is counted in events of the input clocks.
// Summary of operation
// R1: Encoder runs from send clock at twice bit rate; auxiliary output divides encoder clock by 6.
// R2: Encode cycle starts on enable high at tx strobe falling edge; spans twenty periods.
// R3: Next tx strobe rising edge samples sync choice: high command, low data sync.
// R4: Data request goes high for exactly sixteen tx strobe periods.
// R5: Host presents one payload bit per tx strobe rising edge while request is high.
// R6: After sync and sixteen coded bits, one parity bit is appended.
// R7: Enable held high makes the next word follow with no gap.
// R8: Host drops enable before parity bit starts to stop a following word.
// R9: Line drive block low forces both line outputs high; sequencing continues.
// R10: Positive and negative line outputs are both active low.
// R11: Shared reset pulse aborts transmission at a send clock rising edge.
// R12: Shared reset clears both 2:1 counters and the divide-by-6 circuit.
// R13: Decoder samples at 12x bit rate; rx strobe is that clock divided by 12, data aligned.
// R14: Decoder takes a bipolar pair or a non-inverted unipolar input.
// R15: Unused inputs are held at their idle levels by the system.
// R16: Decoder runs freely; output starts after valid sync plus two valid bits.
// R17: Sync kind output high sixteen periods after command sync, low after data sync.
// R18: Data window high while bits are output NRZ, captured on rx strobe rising edge.
// R19: After sixteen bits, odd parity checked; word ok only with no errors.
// R20: Word ok drops after 20 rx strobe periods, or sooner on a new sync; the code drops it early only once a new sync plus two valid bits starts output.
// R21: Decoder reset high at rx strobe rising edge aborts output and resumes hunting.
// R22: Command sync is positive then negative, data sync inverse; one is high then low.
// R23: Encoder parity makes the ones over payload plus parity odd.
`ifndef MCC_DEFINES_SVH
`define MCC_DEFINES_SVH

// APB register byte offsets
`define MCC_ADDR_CTRL      12'h000
`define MCC_ADDR_STATUS    12'h004
`define MCC_ADDR_RXWORD    12'h008

// Control field position and reset value
`define MCC_CTRL_UNI_ONLY  0
`define MCC_CTRL_RESET     1'b0

// Encoder counts, in send clock edges
`define MCC_ENC_LAST       6'h27
`define MCC_ENC_REQ_ON     6'h03
`define MCC_ENC_REQ_OFF    6'h23
`define MCC_ENC_DATA_FIRST 6'h04
`define MCC_ENC_OUT_LAST   6'h27
`define MCC_ENC_PAR_CALC   6'h24
`define MCC_SYNC_HALVES    6'h06
`define MCC_SYNC_HALF_MID  6'h03
`define MCC_PAR_HALF       6'h26

// Divide-by-6 toggles every 3 encoder clock edges
`define MCC_DIV6_TOGGLE    2'h2

// Decoder counts, in decoder clock samples, except bit indices and the word ok span in rx strobe periods
`define MCC_PH_LAST        4'hb
`define MCC_PH_STROBE      4'h6
`define MCC_PH_FIRST_HALF  4'h3
`define MCC_PH_SECOND_HALF 4'h9
`define MCC_SYNC_RUN_MIN   5'h0f
// Wide enough for a first sync half that absorbs the previous parity half
`define MCC_SYNC_RUN_MAX   5'h1b
`define MCC_SYNC_CHECK     5'h09
`define MCC_SYNC_LAST      5'h11
`define MCC_BIT_START      5'h01
`define MCC_BIT_PARITY     5'h10
`define MCC_BIT_END        5'h12
`define MCC_OK_PERIODS     5'h14

`endif

// ==== mcc_pkg.sv ====
// Types shared by the Manchester II word codec.
// Assumes mcc_defines.svh carries the numeric constants.
package mcc_pkg;
  typedef enum logic [1:0] {
    MCC_D_HUNT = 2'b00,
    MCC_D_SYNC = 2'b01,
    MCC_D_BITS = 2'b10
  } mcc_dstate_e;
endpackage : mcc_pkg

// ==== mcc_codec.sv ====
// Manchester II word encoder and decoder with an APB register slave.
// Assumes encoder, send and decoder clocks arrive as slow inputs synchronous to CLK_SYS.
`timescale 1ns/10ps
`include "mcc_defines.svh"

module mcc_codec
  import mcc_pkg::*;
(
  // System
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Shared controls
  input  wire logic        SHARED_RESET,
  input  wire logic        DECODER_RESET,
  // Encoder side
  input  wire logic        ENC_CLK,
  input  wire logic        SEND_CLK,
  input  wire logic        ENCODER_START,
  input  wire logic        SYNC_TYPE_CHOICE,
  input  wire logic        TX_SERIAL_IN,
  input  wire logic        LINE_DRIVE_BLOCK,
  output logic             DIV6_OUT,
  output logic             TX_BIT_STROBE,
  output logic             TX_DATA_REQUEST,
  output logic             TX_POS_N,
  output logic             TX_NEG_N,
  // Decoder side
  input  wire logic        DEC_CLK,
  input  wire logic        RX_POS_IN,
  input  wire logic        RX_NEG_IN,
  input  wire logic        RX_UNI_IN,
  output logic             RX_BIT_STROBE,
  output logic             RX_SERIAL_OUT,
  output logic             RX_DATA_WINDOW,
  output logic             RX_SYNC_KIND,
  output logic             WORD_OK
);

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  // Input clock edge detection
  logic enc_clk_q;
  logic send_clk_q;
  logic dec_clk_q;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      enc_clk_q  <= 1'b0;
      send_clk_q <= 1'b0;
      dec_clk_q  <= 1'b0;
    end else begin
      enc_clk_q  <= ENC_CLK;
      send_clk_q <= SEND_CLK;
      dec_clk_q  <= DEC_CLK;
    end
  end
  wire enc_edge  = ENC_CLK & ~enc_clk_q;
  wire send_edge = SEND_CLK & ~send_clk_q;
  wire dec_edge  = DEC_CLK & ~dec_clk_q;

  // ---------------- Registers ----------------
  logic        ctrl_uni_only;
  logic [15:0] rx_word;
  logic        rx_word_bad;
  logic        enc_busy;
  logic        out_act;
  mcc_dstate_e dstate;

  wire apb_setup  = PSEL & ~PENABLE;
  wire apb_access = PSEL & PENABLE & PREADY;
  wire addr_ok    = (PADDR == `MCC_ADDR_CTRL) || (PADDR == `MCC_ADDR_STATUS) ||
                    (PADDR == `MCC_ADDR_RXWORD);

  // One wait-free answer: ready in the first access cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= apb_setup;
      PSLVERR <= apb_setup & ~addr_ok;
      PRDATA  <= 32'h0000_0000;
      if (apb_setup && !PWRITE) begin
        unique case (PADDR)
          `MCC_ADDR_CTRL:   PRDATA <= {31'h0000_0000, ctrl_uni_only};
          `MCC_ADDR_STATUS: PRDATA <= {26'h000_0000, rx_word_bad, WORD_OK,
                                       RX_DATA_WINDOW, (dstate != MCC_D_HUNT),
                                       out_act, enc_busy};
          `MCC_ADDR_RXWORD: PRDATA <= {16'h0000, rx_word};
          default:          PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ctrl_uni_only <= `MCC_CTRL_RESET;
    end else if (apb_access && PWRITE && PADDR == `MCC_ADDR_CTRL) begin
      ctrl_uni_only <= PWDATA[`MCC_CTRL_UNI_ONLY];
    end
  end

  // ---------------- Encoder ----------------
  logic [1:0]  div_cnt;
  logic        abort_pend;
  logic [5:0]  seq;
  logic        sync_pend;
  logic [15:0] tx_word;
  logic [5:0]  out_h;
  logic        out_cmd;
  logic        par_bit;

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || SHARED_RESET) begin
      div_cnt  <= 2'h0; // R12
      DIV6_OUT <= 1'b0;
    end else if (enc_edge) begin
      if (div_cnt == `MCC_DIV6_TOGGLE) begin
        div_cnt  <= 2'h0;
        DIV6_OUT <= ~DIV6_OUT; // R1
      end else begin
        div_cnt <= div_cnt + 2'h1;
      end
    end
  end

  // 2:1 counter making the shift strobe from the send clock
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || SHARED_RESET) begin
      TX_BIT_STROBE <= 1'b0; // R12
    end else if (send_edge) begin
      TX_BIT_STROBE <= ~TX_BIT_STROBE; // R1
    end
  end

  // Abort is held until a send clock edge, since the send clock may be slow
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      abort_pend <= 1'b0;
    end else if (SHARED_RESET) begin
      abort_pend <= 1'b1;
    end else if (send_edge) begin
      abort_pend <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      enc_busy <= 1'b0;
      seq      <= 6'h00;
    end else if (send_edge) begin
      if (abort_pend || SHARED_RESET) begin
        enc_busy <= 1'b0; // R11
        seq      <= 6'h00;
      end else if (enc_busy && seq != `MCC_ENC_LAST) begin
        seq <= seq + 6'h01; // R2
      end else if (TX_BIT_STROBE && ENCODER_START) begin
        enc_busy <= 1'b1; // R2 R7
        seq      <= 6'h00;
      end else begin
        enc_busy <= 1'b0; // R8
        seq      <= 6'h00;
      end
    end
  end

  wire enc_run = send_edge & enc_busy & ~abort_pend & ~SHARED_RESET;

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      sync_pend <= 1'b0;
    end else if (enc_run && seq == 6'h00) begin
      sync_pend <= SYNC_TYPE_CHOICE; // R3
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      TX_DATA_REQUEST <= 1'b0;
    end else if (send_edge) begin
      if (abort_pend || SHARED_RESET) begin
        TX_DATA_REQUEST <= 1'b0;
      end else if (enc_busy && seq == `MCC_ENC_REQ_ON) begin
        TX_DATA_REQUEST <= 1'b1; // R4
      end else if (enc_busy && seq == `MCC_ENC_REQ_OFF) begin
        TX_DATA_REQUEST <= 1'b0; // R4
      end
    end
  end

  // Payload bit taken as the strobe rises; slot index from the word position
  wire [4:0] bit_slot = 5'(seq[5:1] - 5'h02);
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      tx_word <= 16'h0000;
    end else if (enc_run && TX_DATA_REQUEST && !seq[0] && seq >= `MCC_ENC_DATA_FIRST) begin
      tx_word[bit_slot[3:0]] <= TX_SERIAL_IN; // R5
    end
  end

  // Line output trails the sequencer by one bit so the sync choice is known in time
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      out_act <= 1'b0;
      out_h   <= 6'h00;
      out_cmd <= 1'b0;
    end else if (send_edge) begin
      if (abort_pend || SHARED_RESET) begin
        out_act <= 1'b0; // R11
      end else if (enc_busy && seq == 6'h01) begin
        out_act <= 1'b1;
        out_h   <= 6'h00;
        out_cmd <= sync_pend;
      end else if (out_act) begin
        if (out_h == `MCC_ENC_OUT_LAST) begin
          out_act <= 1'b0;
        end else begin
          out_h <= out_h + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      par_bit <= 1'b0;
    end else if (send_edge && out_act && out_h == `MCC_ENC_PAR_CALC) begin
      par_bit <= ~^tx_word; // R23
    end
  end

  logic       half_pos;
  logic [5:0] data_half;
  always_comb begin
    data_half = 6'(out_h - `MCC_SYNC_HALVES);
    if (out_h < `MCC_SYNC_HALVES) begin
      half_pos = out_cmd ^ (out_h >= `MCC_SYNC_HALF_MID); // R22
    end else if (out_h < `MCC_PAR_HALF) begin
      half_pos = tx_word[data_half[4:1]] ^ out_h[0]; // R22
    end else begin
      half_pos = par_bit ^ out_h[0]; // R6
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      TX_POS_N <= 1'b1;
      TX_NEG_N <= 1'b1;
    end else begin
      TX_POS_N <= ~(LINE_DRIVE_BLOCK & out_act & half_pos);  // R9 R10
      TX_NEG_N <= ~(LINE_DRIVE_BLOCK & out_act & ~half_pos); // R9 R10
    end
  end

  // ---------------- Decoder ----------------
  logic        lvl;
  logic        lvl_neg;
  logic [4:0]  run;
  logic [3:0]  ph;
  logic [4:0]  sc;
  logic [4:0]  bk;
  logic        h1;
  logic        rx_cmd;
  logic        man_err;
  logic [16:0] rx_bits;
  logic [4:0]  ok_cnt;

  // Bipolar pair when enabled, unipolar always; idle levels keep the unused path quiet
  wire line_now = RX_UNI_IN | (~ctrl_uni_only & RX_POS_IN & ~RX_NEG_IN); // R14
  // Idle pair is neither sense, so a data sync from idle still shows its first half
  // Limitation: a unipolar idle looks like one sense and hides a sync starting there
  wire line_neg  = ~line_now & (ctrl_uni_only | RX_NEG_IN); // R14
  wire line_edge = (line_now != lvl) | (line_neg != lvl_neg);
  wire rx_rise  = dec_edge && ph == 4'(`MCC_PH_STROBE - 4'h1);
  wire dec_abort = SHARED_RESET || (rx_rise && DECODER_RESET);
  wire bit_check = dec_edge && dstate == MCC_D_BITS && ph == `MCC_PH_SECOND_HALF &&
                   bk <= `MCC_BIT_PARITY;
  wire bit_good  = line_now != h1;
  wire start_out = bit_check && bk == `MCC_BIT_START && bit_good && !man_err;
  wire ph_wrap   = dec_edge && ph == `MCC_PH_LAST;

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      lvl     <= 1'b0;
      lvl_neg <= 1'b0;
      run     <= 5'h00;
    end else if (dec_edge) begin
      lvl     <= line_now; // R16
      lvl_neg <= line_neg;
      if (line_edge) begin
        run <= 5'h01;
      end else if (run != 5'h1f) begin
        run <= run + 5'h01;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ph <= 4'h0;
    end else if (SHARED_RESET) begin
      ph <= 4'h0; // R12
    end else if (dec_edge) begin
      if (dstate == MCC_D_HUNT && line_edge &&
          run >= `MCC_SYNC_RUN_MIN && run <= `MCC_SYNC_RUN_MAX) begin
        ph <= `MCC_PH_STROBE; // R13
      end else if (ph == `MCC_PH_LAST) begin
        ph <= 4'h0;
      end else begin
        ph <= ph + 4'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      RX_BIT_STROBE <= 1'b0;
    end else begin
      RX_BIT_STROBE <= ph >= `MCC_PH_STROBE; // R13
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      dstate  <= MCC_D_HUNT;
      sc      <= 5'h00;
      bk      <= 5'h00;
      rx_cmd  <= 1'b0;
      h1      <= 1'b0;
      man_err <= 1'b0;
      rx_bits <= 17'h0_0000;
    end else if (dec_abort) begin
      dstate <= MCC_D_HUNT; // R21
      bk     <= 5'h00;
    end else if (dec_edge) begin
      unique case (dstate)
        MCC_D_HUNT: begin
          if (line_edge && run >= `MCC_SYNC_RUN_MIN && run <= `MCC_SYNC_RUN_MAX) begin
            dstate  <= MCC_D_SYNC;
            rx_cmd  <= lvl; // R22
            sc      <= 5'h00;
            man_err <= 1'b0;
          end
        end
        MCC_D_SYNC: begin
          sc <= sc + 5'h01;
          if (sc == `MCC_SYNC_CHECK && line_now == rx_cmd) begin
            dstate <= MCC_D_HUNT;
          end else if (sc == `MCC_SYNC_LAST) begin
            dstate <= MCC_D_BITS;
            bk     <= 5'h00;
          end
        end
        MCC_D_BITS: begin
          if (ph == `MCC_PH_FIRST_HALF) begin
            h1 <= line_now;
          end
          if (bit_check) begin
            rx_bits[bk] <= h1; // R22
            if (!bit_good) begin
              if (bk <= `MCC_BIT_START) begin
                dstate <= MCC_D_HUNT; // R16
              end
              man_err <= 1'b1;
            end
          end
          if (ph == `MCC_PH_LAST) begin
            if (bk == 5'(`MCC_BIT_END - 5'h01)) begin
              dstate <= MCC_D_HUNT;
              bk     <= 5'h00;
            end else begin
              bk <= bk + 5'h01;
            end
          end
        end
        default: dstate <= MCC_D_HUNT;
      endcase
    end
  end

  // Output lags decoding by two bits, so the window opens only on a proven word start
  logic win_armed;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      win_armed      <= 1'b0;
      RX_DATA_WINDOW <= 1'b0;
      RX_SYNC_KIND   <= 1'b0;
      RX_SERIAL_OUT  <= 1'b0;
    end else if (dec_abort) begin
      win_armed      <= 1'b0; // R21
      RX_DATA_WINDOW <= 1'b0;
      RX_SYNC_KIND   <= 1'b0;
    end else if (start_out) begin
      win_armed <= 1'b1; // R16
    end else if (ph_wrap && win_armed) begin
      if (bk == 5'(`MCC_BIT_END - 5'h01)) begin
        win_armed      <= 1'b0;
        RX_DATA_WINDOW <= 1'b0;
        RX_SYNC_KIND   <= 1'b0;
        RX_SERIAL_OUT  <= 1'b0;
      end else begin
        RX_DATA_WINDOW <= 1'b1; // R18
        RX_SYNC_KIND   <= rx_cmd; // R17
        RX_SERIAL_OUT  <= rx_bits[4'(bk - 5'h01)]; // R18
      end
    end
  end

  wire word_end = ph_wrap && win_armed && !dec_abort && bk == 5'(`MCC_BIT_END - 5'h01);
  wire word_par = ^rx_bits;

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      WORD_OK     <= 1'b0;
      ok_cnt      <= 5'h00;
      rx_word     <= 16'h0000;
      rx_word_bad <= 1'b0;
    end else if (word_end) begin
      WORD_OK     <= word_par & ~man_err; // R19
      ok_cnt      <= 5'h00;
      rx_word     <= rx_bits[15:0];
      rx_word_bad <= ~word_par | man_err;
    end else if (start_out) begin
      WORD_OK <= 1'b0; // R20
    end else if (rx_rise && WORD_OK) begin
      if (ok_cnt == 5'(`MCC_OK_PERIODS - 5'h01)) begin
        WORD_OK <= 1'b0; // R20
      end else begin
        ok_cnt <= ok_cnt + 5'h01;
      end
    end
  end

  // ---------------- Checks ----------------
  logic [4:0] req_rises;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || !TX_DATA_REQUEST) begin
      req_rises <= 5'h00;
    end else if (send_edge && !TX_BIT_STROBE) begin
      req_rises <= req_rises + 5'h01;
    end
  end

  line_inhibit_a: assert property (!LINE_DRIVE_BLOCK |=> TX_POS_N && TX_NEG_N) // R9
    else $error("line outputs driven while blocked");
  line_sense_a: assert property (!(!TX_POS_N && !TX_NEG_N)) // R10
    else $error("both line senses active");
  req_len_a: assert property ($fell(TX_DATA_REQUEST) && // R4
                              !$past(abort_pend || SHARED_RESET) |->
                              $past(req_rises) == 5'h10)
    else $error("data request not sixteen strobe periods");
  enc_start_a: assert property (send_edge && !enc_busy && TX_BIT_STROBE && ENCODER_START && // R2
                                !abort_pend && !SHARED_RESET |=> enc_busy && seq == 6'h00)
    else $error("encode cycle did not start");
  sync_take_a: assert property (enc_run && seq == 6'h00 |=> // R3
                                sync_pend == $past(SYNC_TYPE_CHOICE) && TX_BIT_STROBE)
    else $error("sync choice not sampled at strobe rise");
  enc_parity_a: assert property (out_act && out_h == `MCC_PAR_HALF |-> ^{tx_word, par_bit}) // R23
    else $error("encoder parity not odd");
  master_reset_a: assert property (SHARED_RESET |=> div_cnt == 2'h0 && !DIV6_OUT && // R12
                                   !TX_BIT_STROBE && ph == 4'h0)
    else $error("shared reset left a counter running");
  dec_reset_a: assert property (rx_rise && DECODER_RESET |=> dstate == MCC_D_HUNT && // R21
                                !win_armed ##1 !RX_DATA_WINDOW)
    else $error("decoder reset did not abort");
  sync_kind_a: assert property (RX_SYNC_KIND |-> RX_DATA_WINDOW) // R17
    else $error("sync kind outside data window");
  word_ok_a: assert property ($rose(WORD_OK) |-> !$past(man_err) && !RX_DATA_WINDOW) // R19
    else $error("word ok raised on bad word");

endmodule : mcc_codec

// ==== mcc_host_model.sv ====
// Host shift registers and loopback partner for the Manchester word codec.
// Assumes it runs on CLK_SYS and sees the codec's strobes as sampled levels.
`timescale 1ns/10ps
module mcc_host_model (
  // Clock
  input  wire logic        clk,
  // Encoder side
  input  wire logic [15:0] tx_word,
  input  wire logic        tx_strobe,
  input  wire logic        tx_req,
  output logic             tx_bit,
  output logic [4:0]       req_cnt,
  // Decoder side
  input  wire logic        rx_strobe,
  input  wire logic        rx_window,
  input  wire logic        rx_bit,
  input  wire logic        rx_kind,
  output logic [15:0]      rx_word,
  output logic [4:0]       rx_cnt,
  output logic             rx_sync
);
  logic       tx_q;
  logic       req_q;
  logic       rx_q;
  logic       win_q;
  logic [3:0] idx;

  initial begin
    idx     = 4'h0;
    req_cnt = 5'h00;
    rx_cnt  = 5'h00;
  end

  // Outside a request the source no longer holds its bit
  assign tx_bit = tx_req ? tx_word[idx] : ~tx_word[idx];

  always @(posedge clk) begin
    tx_q  <= tx_strobe;
    req_q <= tx_req;
    if (tx_req && !req_q) begin
      idx     <= 4'h0;
      req_cnt <= 5'h00;
    end else if (tx_strobe && !tx_q && tx_req) begin
      // Advance only after the codec has taken the bit
      idx     <= idx + 4'h1;
      req_cnt <= req_cnt + 5'h01;
    end
  end

  always @(posedge clk) begin
    rx_q  <= rx_strobe;
    win_q <= rx_window;
    if (rx_window && !win_q) begin
      rx_cnt <= 5'h00;
    end else if (rx_strobe && !rx_q && rx_window) begin
      rx_word[rx_cnt[3:0]] <= rx_bit;
      rx_cnt               <= rx_cnt + 5'h01;
      rx_sync              <= rx_kind;
    end
  end
endmodule : mcc_host_model

// ==== mcc_codec_tb.sv ====
// Self-checking bench for the Manchester word codec, encoder looped to decoder.
// Assumes the codec's APB map and the host model in mcc_host_model.sv.
`timescale 1ns/10ps
`include "mcc_defines.svh"
module mcc_codec_tb;
  logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sh_rst, dec_rst, enc_clk, dec_clk, start, choice, ldb, use_uni;
  logic        div6, txs, txreq, txp_n, txn_n, tx_in, rxs, rxo, rxw, rxk, wok;
  logic        rxp, rxn, rxu, er, c, ok_q, d6_q, e_q, rx_sync;
  logic [15:0] tx_word, rx_word, d;
  logic [4:0]  req_cnt, rx_cnt;
  logic [3:0]  div;
  int          failures, checks_done, seed, oks, lows, span, ec, o, l, i;

  // Loopback through a transceiver; idle pins held as the system must
  assign rxp = use_uni ? 1'b0 : ~txp_n;
  assign rxn = use_uni ? 1'b1 : ~txn_n;
  assign rxu = use_uni ? txn_n : 1'b0;

  mcc_codec dut_u (.CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SHARED_RESET(sh_rst), .DECODER_RESET(dec_rst),
    .ENC_CLK(enc_clk), .SEND_CLK(div6), .ENCODER_START(start),
    .SYNC_TYPE_CHOICE(choice), .TX_SERIAL_IN(tx_in), .LINE_DRIVE_BLOCK(ldb),
    .DIV6_OUT(div6), .TX_BIT_STROBE(txs), .TX_DATA_REQUEST(txreq), .TX_POS_N(txp_n),
    .TX_NEG_N(txn_n), .DEC_CLK(dec_clk), .RX_POS_IN(rxp), .RX_NEG_IN(rxn),
    .RX_UNI_IN(rxu), .RX_BIT_STROBE(rxs), .RX_SERIAL_OUT(rxo),
    .RX_DATA_WINDOW(rxw), .RX_SYNC_KIND(rxk), .WORD_OK(wok));

  mcc_host_model host_u (.clk(clk_sys), .tx_word(tx_word), .tx_strobe(txs),
    .tx_req(txreq), .tx_bit(tx_in), .req_cnt(req_cnt), .rx_strobe(rxs),
    .rx_window(rxw), .rx_bit(rxo), .rx_kind(rxk), .rx_word(rx_word),
    .rx_cnt(rx_cnt), .rx_sync(rx_sync));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Both slow clocks at 12x the bit rate, opposite phase
  always @(posedge clk_sys) begin
    div     <= div + 4'h1;
    enc_clk <= div[1];
    dec_clk <= ~div[1];
    ok_q    <= wok;
    e_q     <= enc_clk;
    d6_q    <= div6;
    if (wok && !ok_q) oks <= oks + 1;
    if (!txp_n || !txn_n) lows <= lows + 1;
    if (div6 && !d6_q) span <= ec;
    ec <= ((div6 && !d6_q) ? 0 : ec) + int'(enc_clk && !e_q);
  end

  function automatic logic [31:0] rxw_exp(input logic [15:0] v);
    return {16'h0000, v};
  endfunction : rxw_exp

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    chk("wait level", {31'h0, v}, {31'h0, s});
  endtask : wait_lvl

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic word(input logic [15:0] v, input logic s, input logic hold);
    tx_word <= v;
    choice  <= s;
    start   <= 1'b1;
    wait_lvl(txreq, 1'b1);
    // Dropped well before parity unless words are chained
    start <= hold;
    wait_lvl(txreq, 1'b0);
  endtask : word

  task automatic rx_check(input logic [15:0] v, input logic s);
    wait_lvl(wok, 1'b0);
    wait_lvl(wok, 1'b1);
    chk("rx word", rxw_exp(v), rxw_exp(rx_word));
    chk("rx bits", 32'd16, {27'h0, rx_cnt});
    chk("sync kind", {31'h0, s}, {31'h0, rx_sync});
    chk("req periods", 32'd16, {27'h0, req_cnt});
    apb(1'b0, `MCC_ADDR_RXWORD, 32'h0);
    chk("rxword reg", rxw_exp(v), rd);
  endtask : rx_check

  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  initial begin
    cyc(60000);
    failures++;
    results;
  end

  initial begin
    seed = 65173;
    {failures, checks_done, oks, lows, span, ec} = '0;
    {rstn, psel, penable, pwrite, sh_rst, dec_rst, enc_clk, dec_clk} = '0;
    {start, choice, use_uni, ok_q, d6_q, e_q} = '0;
    {paddr, pwdata, tx_word, div} = '0;
    ldb = 1'b1;
    cyc(5);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk("line idle", 32'h3, {30'h0, txp_n, txn_n});
    apb(1'b1, `MCC_ADDR_CTRL, 32'h1);
    apb(1'b0, `MCC_ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b1, `MCC_ADDR_CTRL, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    cyc(100);
    chk("div6 span", 32'd6, span);
    for (i = 0; i < 6; i++) begin
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($random(seed));
      c = 1'($random(seed));
      word(d, c, 1'b0);
      rx_check(d, c);
    end
    // Chained words: both must decode good
    o = oks;
    word(16'($random(seed)), 1'b1, 1'b1);
    d = 16'($random(seed));
    word(d, 1'b0, 1'b0);
    rx_check(d, 1'b0);
    cyc(2);
    chk("chained oks", 32'd2, oks - o);
    apb(1'b1, `MCC_ADDR_CTRL, 32'h1);
    use_uni <= 1'b1;
    // Unipolar idle sits high, so only a data sync has a clean first half
    d = 16'($random(seed));
    word(d, 1'b0, 1'b0);
    rx_check(d, 1'b0);
    use_uni <= 1'b0;
    apb(1'b1, `MCC_ADDR_CTRL, 32'h0);
    o = oks;
    l = lows;
    ldb <= 1'b0;
    word(16'($random(seed)), 1'b1, 1'b0);
    cyc(600);
    chk("blocked line", 32'd0, lows - l);
    chk("blocked req", 32'd16, {27'h0, req_cnt});
    chk("blocked oks", 32'd0, oks - o);
    ldb <= 1'b1;
    cyc(1200);
    o = oks;
    tx_word <= 16'($random(seed));
    start   <= 1'b1;
    wait_lvl(rxw, 1'b1);
    start   <= 1'b0;
    dec_rst <= 1'b1;
    cyc(60);
    dec_rst <= 1'b0;
    chk("window abort", 32'h0, {31'h0, rxw});
    cyc(1500);
    chk("abort oks", 32'd0, oks - o);
    start <= 1'b1;
    wait_lvl(txreq, 1'b1);
    start  <= 1'b0;
    sh_rst <= 1'b1;
    cyc(30);
    sh_rst <= 1'b0;
    cyc(60);
    chk("abort req", 32'h0, {31'h0, txreq});
    apb(1'b0, `MCC_ADDR_STATUS, 32'h0);
    chk("enc busy", 32'h0, {31'h0, rd[0]});
    d = 16'($random(seed));
    word(d, 1'b1, 1'b0);
    rx_check(d, 1'b1);
    // Word ok stands about 20 rx strobe periods of 48 system clocks
    o = 0;
    while (wok === 1'b1 && o < 2000) begin
      @(posedge clk_sys);
      o++;
    end
    chk("ok span", 32'h1, {31'h0, (o > 912 && o < 1008)});
    results;
  end
endmodule : mcc_codec_tb
